// ### tcd_pkg.sv
// Shared constants and opcodes for the timer command decoder.
package tcd_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned NCNT   = 5;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_DATA   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CMD    = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_PTR    = 4'hC;

    // ------------------------------------------------------------------
    // Command classes in bits 7:5 of the command byte
    // ------------------------------------------------------------------
    localparam logic [2:0] CC_PTR     = 3'h0;
    localparam logic [2:0] CC_ARM     = 3'h1;
    localparam logic [2:0] CC_LOAD    = 3'h2;
    localparam logic [2:0] CC_LDARM   = 3'h3;
    localparam logic [2:0] CC_DISSAVE = 3'h4;
    localparam logic [2:0] CC_SAVE    = 3'h5;
    localparam logic [2:0] CC_DISARM  = 3'h6;
    localparam logic [2:0] CC_MISC    = 3'h7;

    // Sub codes in bits 4:3 of a misc command.
    localparam logic [1:0] SC_CLR     = 2'h0;
    localparam logic [1:0] SC_SET     = 2'h1;
    localparam logic [1:0] SC_STEP    = 2'h2;

    // Counter number field values that select master-mode bits.
    localparam logic [2:0] N_SEQ      = 3'h0;
    localparam logic [2:0] N_WIDE     = 3'h7;

    // ------------------------------------------------------------------
    // Master-mode and counter-mode bit positions and toggle output mode code
    // ------------------------------------------------------------------
    localparam int unsigned MM_SEQ_DIS  = 14;
    localparam int unsigned MM_WIDE     = 13;
    localparam int unsigned CM_DIR      = 3;
    localparam int unsigned CM_ALT      = 4;
    localparam int unsigned CM_ONESHOT  = 5;
    localparam int unsigned CM_GATESEL  = 6;
    localparam logic [2:0]  OM_TOGGLE   = 3'h2;

    // ------------------------------------------------------------------
    // Data pointer codes
    // ------------------------------------------------------------------
    localparam logic [1:0] EL_MODE    = 2'h0;
    localparam logic [1:0] EL_LOAD    = 2'h1;
    localparam logic [1:0] EL_HOLD    = 2'h2;
    localparam logic [2:0] GR_FIRST   = 3'h1;
    localparam logic [2:0] GR_LAST    = 3'h5;
    localparam logic [2:0] GR_BAD0    = 3'h0;
    localparam logic [2:0] GR_BAD6    = 3'h6;
    localparam logic [2:0] GR_CTRL    = 3'h7;

    // ------------------------------------------------------------------
    // Reset values and count limits
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [15:0] RST_CM    = 16'h0800;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;

endpackage

// ### tcd_if.sv
// Carrier between the decoder core, the data pointer and the byte lane unit.
`timescale 1ns/1ns
interface tcd_if;
    logic        ptr_ld;
    logic [1:0]  ptr_e;
    logic [2:0]  ptr_g;
    logic        acc;
    logic        seq_dis;
    logic        wide;
    logic [1:0]  elem;
    logic [2:0]  grp;
    logic        byte_ptr;
    logic        wr;
    logic [15:0] wdata;
    logic        word_wr;
    logic [15:0] word_data;
    logic [15:0] rd_word;
    logic [15:0] rd_bus;

    modport core_mp (output ptr_ld, ptr_e, ptr_g, acc, seq_dis, wide, wr, wdata, rd_word,
                     input  elem, grp, byte_ptr, word_wr, word_data, rd_bus);
    modport ptr_mp  (input  ptr_ld, ptr_e, ptr_g, acc, seq_dis, wide,
                     output elem, grp, byte_ptr);
    modport bus_mp  (input  wr, wdata, wide, byte_ptr, rd_word,
                     output word_wr, word_data, rd_bus);
endinterface

// ### tcd_ptr.sv
// Data pointer with element, group and byte pointer fields.
`timescale 1ns/1ns
module tcd_ptr (
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    tcd_if.ptr_mp     pif
);
    import tcd_pkg::*;

    typedef struct packed {
        logic [1:0] elem;
        logic [2:0] grp;
        logic       bp;
    } tcd_ptr_s;

    tcd_ptr_s s_q;
    tcd_ptr_s s_d;

    always_comb begin
        s_d = s_q;
        // RULE15: pointer load.
        // RULE16: valid groups only.
        if (pif.ptr_ld && pif.ptr_g != GR_BAD0 && pif.ptr_g != GR_BAD6) begin
            s_d.elem = pif.ptr_e;
            s_d.grp  = pif.ptr_g;
            s_d.bp   = 1'b1;
        end else if (pif.acc) begin
            if (!pif.wide && s_q.bp) begin
                s_d.bp = 1'b0;
            end else begin
                s_d.bp = 1'b1;
                // RULE18: sequencing when enabled.
                if (!pif.seq_dis && s_q.grp != GR_CTRL) begin
                    if (s_q.elem >= EL_HOLD) begin
                        s_d.elem = EL_MODE;
                        s_d.grp  = (s_q.grp >= GR_LAST) ? GR_FIRST : s_q.grp + 3'h1;
                    end else begin
                        s_d.elem = s_q.elem + 2'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_q <= '{elem: EL_MODE, grp: GR_FIRST, bp: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign pif.elem     = s_q.elem;
    assign pif.grp      = s_q.grp;
    assign pif.byte_ptr = s_q.bp;
endmodule

// ### tcd_bus.sv
// Byte lane unit that joins or splits words for the eight-bit bus mode.
`timescale 1ns/1ns
module tcd_bus (
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    tcd_if.bus_mp     bif
);
    import tcd_pkg::*;

    typedef struct packed {
        logic [7:0] lo;
    } tcd_bus_s;

    tcd_bus_s s_q;
    tcd_bus_s s_d;

    // RULE20: byte or word transfer.
    always_comb begin
        s_d           = s_q;
        bif.word_wr   = bif.wr && (bif.wide || !bif.byte_ptr);
        bif.word_data = bif.wide ? bif.wdata : {bif.wdata[7:0], s_q.lo};
        bif.rd_bus    = bif.wide ? bif.rd_word
                      : {8'h00, (bif.byte_ptr ? bif.rd_word[7:0] : bif.rd_word[15:8])};
        if (bif.wr && !bif.wide && bif.byte_ptr) begin
            s_d.lo = bif.wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_q <= '{lo: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ### tcd_top.sv
// Command decoder and counter control for a five-counter timing controller.
// Behaviour
// RULE1: Load copies Load or Hold register into selected counters; sources unchanged.
// RULE2: Load transfer happens regardless of counter configuration or arm state.
// RULE3: Load one count before terminal count enters terminal count, normal source.
// RULE4: Load during terminal count ends it without altering the pending source.
// RULE5: Armed use upcoming source, disarmed use Load, gate modes use gate.
// RULE6: Load-made terminal count flips alternating source; terminal-ending load does not.
// RULE7: Load-and-arm acts as load then arm, re-enabling one-shot counters.
// RULE8: Arming in alternating mode makes next terminal count reload from Hold.
// RULE9: Disarm stops counting; in terminal count waits one count; load-arm cancels.
// RULE10: Disarmed counters still load and save; counting resumes after arm.
// RULE11: Save copies counter value into Hold without disturbing counting.
// RULE12: Disarm-and-save equals disarm followed by save.
// RULE13: Set or clear toggle of counter one to five; shown in mode 010.
// RULE14: Step moves counter by one per direction bit, even when disarmed.
// RULE15: Pointer load copies element and group fields and sets byte pointer.
// RULE16: Pointer updates only for groups 001 to 101 and 111.
// RULE17: Sequencing commands set or clear master-mode bit 14 only.
// RULE18: Pointer stays put when sequencing disabled, advances when enabled.
// RULE19: Bus commands set or clear master-mode bit 13 only.
// RULE20: Wide mode uses sixteen lines; narrow mode passes bytes on low lines.
// RULE21: Full word write to master mode also sets these bits.
// RULE22: Host avoids load-and-arm with counters asynchronous to commands.
// RULE23: Host issues each command as one byte to the command register.
// RULE24: Each select bit addresses one counter; zero leaves it untouched.
// RULE25: Host never writes unused command codes.
// RULE26: Mask commands act on all selected counters in one cycle.
`timescale 1ns/1ns
module tcd_top (
    input  wire logic                          ref_clk_i,
    input  wire logic                          resetn_i,
    input  wire logic [tcd_pkg::ADDR_W-1:0]    reg_addr_i,
    input  wire logic [tcd_pkg::DATA_W-1:0]    reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    input  wire logic [tcd_pkg::NCNT-1:0]      src_edge_i,
    input  wire logic [tcd_pkg::NCNT-1:0]      gate_i,
    output logic      [tcd_pkg::DATA_W-1:0]    reg_rdata_o,
    output logic      [tcd_pkg::NCNT-1:0]      cnt_out_o,
    output logic      [tcd_pkg::NCNT-1:0]      tc_o,
    output logic                               wide_bus_o
);
    import tcd_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NCNT-1:0]              armed;
        logic [NCNT-1:0]              tc;
        logic [NCNT-1:0]              pend_dis;
        logic [NCNT-1:0]              use_hold;
        logic [NCNT-1:0]              tgl;
        logic [NCNT-1:0]              outp;
        logic [NCNT-1:0][DATA_W-1:0]  cnt;
        logic [NCNT-1:0][DATA_W-1:0]  ld;
        logic [NCNT-1:0][DATA_W-1:0]  hd;
        logic [NCNT-1:0][DATA_W-1:0]  cm;
        logic [DATA_W-1:0]            mm;
        logic [DATA_W-1:0]            rdata;
    } tcd_core_s;

    tcd_core_s s_q;
    tcd_core_s s_d;
    tcd_if     cif ();

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic              cmd_wr;
    logic              data_wr;
    logic              data_rd;
    logic [7:0]        cmd;
    logic [2:0]        cls;
    logic [1:0]        sub;
    logic [2:0]        num;
    logic [NCNT-1:0]   sel;
    logic              is_arm;
    logic              is_load;
    logic              is_ldarm;
    logic              is_dis;
    logic              is_save;
    logic              is_dissave;
    logic              is_misc;

    assign cmd_wr     = reg_wr_i && reg_addr_i == OFS_CMD;
    assign data_wr    = reg_wr_i && reg_addr_i == OFS_DATA;
    assign data_rd    = reg_rd_i && reg_addr_i == OFS_DATA;
    // RULE23: one command byte.
    assign cmd        = reg_wdata_i[7:0];
    assign cls        = cmd[7:5];
    assign sub        = cmd[4:3];
    assign num        = cmd[2:0];
    // RULE24: select mask decode.
    assign sel        = cmd[NCNT-1:0];
    assign is_arm     = cmd_wr && cls == CC_ARM;
    assign is_load    = cmd_wr && cls == CC_LOAD;
    assign is_ldarm   = cmd_wr && cls == CC_LDARM;
    assign is_dis     = cmd_wr && cls == CC_DISARM;
    assign is_save    = cmd_wr && cls == CC_SAVE;
    assign is_dissave = cmd_wr && cls == CC_DISSAVE;
    assign is_misc    = cmd_wr && cls == CC_MISC;

    // ------------------------------------------------------------------
    // Data pointer and byte lanes
    // ------------------------------------------------------------------
    assign cif.ptr_ld  = cmd_wr && cls == CC_PTR;
    assign cif.ptr_e   = cmd[4:3];
    assign cif.ptr_g   = cmd[2:0];
    assign cif.acc     = data_wr || data_rd;
    assign cif.seq_dis = s_q.mm[MM_SEQ_DIS];
    assign cif.wide    = s_q.mm[MM_WIDE];
    assign cif.wr      = data_wr;
    assign cif.wdata   = reg_wdata_i;

    tcd_ptr u_ptr (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .pif       (cif.ptr_mp)
    );

    tcd_bus u_bus (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .bif       (cif.bus_mp)
    );

    // Word at the current data pointer location.
    always_comb begin
        cif.rd_word = RST_WORD;
        if (cif.grp == GR_CTRL) begin
            if (cif.elem == EL_MODE) begin
                cif.rd_word = s_q.mm;
            end
        end else begin
            for (int i = 0; i < NCNT; i++) begin
                if (cif.grp == 3'(i + 1)) begin
                    if (cif.elem == EL_MODE) begin
                        cif.rd_word = s_q.cm[i];
                    end else if (cif.elem == EL_LOAD) begin
                        cif.rd_word = s_q.ld[i];
                    end else if (cif.elem == EL_HOLD) begin
                        cif.rd_word = s_q.hd[i];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic            do_load;
        logic            do_arm;
        logic            do_dis;
        logic            do_save;
        logic            do_step;
        logic            cnt_ev;
        logic            pre;
        logic            src_hold;
        logic            dir_up;
        logic [DATA_W-1:0] nxt;
        do_load  = 1'b0;
        do_arm   = 1'b0;
        do_dis   = 1'b0;
        do_save  = 1'b0;
        do_step  = 1'b0;
        cnt_ev   = 1'b0;
        pre      = 1'b0;
        src_hold = 1'b0;
        dir_up   = 1'b0;
        nxt      = RST_WORD;
        s_d      = s_q;

        // RULE26: all selected in one cycle.
        for (int i = 0; i < NCNT; i++) begin
            do_load  = (is_load || is_ldarm) && sel[i];
            do_arm   = (is_arm || is_ldarm) && sel[i];
            do_dis   = (is_dis || is_dissave) && sel[i];
            do_save  = (is_save || is_dissave) && sel[i];
            // RULE14: step by direction.
            do_step  = is_misc && sub == SC_STEP && num == 3'(i + 1);
            cnt_ev   = do_step || (s_q.armed[i] && src_edge_i[i]);
            dir_up   = s_q.cm[i][CM_DIR];
            pre      = dir_up ? (s_q.cnt[i] == CNT_MAX) : (s_q.cnt[i] == CNT_ONE);
            nxt      = dir_up ? s_q.cnt[i] + CNT_ONE : s_q.cnt[i] - CNT_ONE;
            // RULE5: reload source choice.
            if (s_q.cm[i][CM_GATESEL]) begin
                src_hold = gate_i[i];
            end else if (s_q.cm[i][CM_ALT]) begin
                src_hold = s_q.use_hold[i];
            end else begin
                src_hold = 1'b0;
            end

            // RULE1: load transfer.
            // RULE2: regardless of arm state.
            if (do_load) begin
                if (s_q.tc[i]) begin
                    // RULE4: load ends terminal count.
                    s_d.tc[i]  = 1'b0;
                    s_d.cnt[i] = ((s_q.armed[i] || s_q.cm[i][CM_GATESEL]) && src_hold)
                               ? s_q.hd[i] : s_q.ld[i];
                    // RULE9: pending disarm on exit.
                    if (s_q.pend_dis[i]) begin
                        s_d.armed[i]    = 1'b0;
                        s_d.pend_dis[i] = 1'b0;
                    end
                end else if (pre) begin
                    // RULE3: load enters terminal count.
                    s_d.tc[i]  = 1'b1;
                    s_d.tgl[i] = ~s_q.tgl[i];
                    s_d.cnt[i] = src_hold ? s_q.hd[i] : s_q.ld[i];
                    // RULE6: load made terminal flips.
                    if (s_q.cm[i][CM_ALT]) begin
                        s_d.use_hold[i] = ~s_q.use_hold[i];
                    end
                    if (s_q.cm[i][CM_ONESHOT]) begin
                        s_d.armed[i] = 1'b0;
                    end
                end else begin
                    s_d.cnt[i] = ((s_q.armed[i] || s_q.cm[i][CM_GATESEL]) && src_hold)
                               ? s_q.hd[i] : s_q.ld[i];
                end
            end else if (cnt_ev) begin
                // RULE10: disarmed counters hold.
                if (s_q.tc[i]) begin
                    s_d.tc[i]  = 1'b0;
                    s_d.cnt[i] = nxt;
                    if (s_q.pend_dis[i]) begin
                        s_d.armed[i]    = 1'b0;
                        s_d.pend_dis[i] = 1'b0;
                    end
                end else if (pre) begin
                    s_d.tc[i]  = 1'b1;
                    s_d.tgl[i] = ~s_q.tgl[i];
                    s_d.cnt[i] = src_hold ? s_q.hd[i] : s_q.ld[i];
                    if (s_q.cm[i][CM_ALT]) begin
                        s_d.use_hold[i] = ~s_q.use_hold[i];
                    end
                    if (s_q.cm[i][CM_ONESHOT]) begin
                        s_d.armed[i] = 1'b0;
                    end
                end else begin
                    s_d.cnt[i] = nxt;
                end
            end

            // RULE7: arm after load.
            // RULE8: next reload from Hold.
            if (do_arm) begin
                s_d.armed[i]    = 1'b1;
                s_d.pend_dis[i] = 1'b0;
                s_d.use_hold[i] = 1'b1;
            end

            // RULE9: disarm or defer.
            // RULE12: disarm then save.
            if (do_dis) begin
                if (s_q.tc[i]) begin
                    s_d.pend_dis[i] = 1'b1;
                end else begin
                    s_d.armed[i] = 1'b0;
                end
            end

            // RULE11: save into Hold.
            if (do_save) begin
                s_d.hd[i] = s_q.cnt[i];
            end

            // RULE13: toggle preset.
            if (is_misc && num == 3'(i + 1)) begin
                if (sub == SC_SET) begin
                    s_d.tgl[i] = 1'b1;
                end else if (sub == SC_CLR) begin
                    s_d.tgl[i] = 1'b0;
                end
            end

            // Word writes through the data port.
            if (cif.word_wr && cif.grp == 3'(i + 1)) begin
                if (cif.elem == EL_MODE) begin
                    s_d.cm[i] = cif.word_data;
                end else if (cif.elem == EL_LOAD) begin
                    s_d.ld[i] = cif.word_data;
                end else if (cif.elem == EL_HOLD) begin
                    s_d.hd[i] = cif.word_data;
                end
            end

            s_d.outp[i] = (s_d.cm[i][2:0] == OM_TOGGLE) ? s_d.tgl[i] : s_d.tc[i];
        end

        // RULE17: sequencing bit commands.
        // RULE19: bus width bit commands.
        if (is_misc && num == N_SEQ && sub == SC_SET) begin
            s_d.mm[MM_SEQ_DIS] = 1'b1;
        end else if (is_misc && num == N_SEQ && sub == SC_CLR) begin
            s_d.mm[MM_SEQ_DIS] = 1'b0;
        end else if (is_misc && num == N_WIDE && sub == SC_SET) begin
            s_d.mm[MM_WIDE] = 1'b1;
        end else if (is_misc && num == N_WIDE && sub == SC_CLR) begin
            s_d.mm[MM_WIDE] = 1'b0;
        end

        // RULE21: full master mode write.
        if (cif.word_wr && cif.grp == GR_CTRL && cif.elem == EL_MODE) begin
            s_d.mm = cif.word_data;
        end

        // Read data for the cycle after the strobe.
        s_d.rdata = RST_WORD;
        if (reg_rd_i) begin
            if (reg_addr_i == OFS_DATA) begin
                s_d.rdata = cif.rd_bus;
            end else if (reg_addr_i == OFS_STATUS) begin
                s_d.rdata = {1'b0, s_q.pend_dis, s_q.tc, s_q.armed};
            end else if (reg_addr_i == OFS_PTR) begin
                s_d.rdata = {10'h000, cif.byte_ptr, cif.grp, cif.elem};
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_q.armed    <= '0;
            s_q.tc       <= '0;
            s_q.pend_dis <= '0;
            s_q.use_hold <= '1;
            s_q.tgl      <= '0;
            s_q.outp     <= '0;
            s_q.cnt      <= '0;
            s_q.ld       <= '0;
            s_q.hd       <= '0;
            s_q.cm       <= {NCNT{RST_CM}};
            s_q.mm       <= RST_WORD;
            s_q.rdata    <= RST_WORD;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign cnt_out_o   = s_q.outp;
    assign tc_o        = s_q.tc;
    assign wide_bus_o  = s_q.mm[MM_WIDE];
endmodule

// ### tcd_host.sv
// Host model that issues register cycles on the command port.
`timescale 1ns/1ns
module tcd_host (
    input  wire logic        ref_clk_i,
    input  wire logic [15:0] rdata_i,
    output logic      [3:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge ref_clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(posedge ref_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
        #1 q = rdata_i;
    endtask
endmodule

// ### tcd_chk.sv
// Port-level assertions for the timer command decoder.
`timescale 1ns/1ns
module tcd_chk import tcd_pkg::*; (
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [4:0]  src_edge_i,
    input wire logic [4:0]  tc_o,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        wide_bus_o
);
    wire       cmd = reg_wr_i && reg_addr_i == OFS_CMD;
    wire       src = |src_edge_i;
    wire [7:0] op  = reg_wdata_i[7:0];
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside its slot");
    a_wide_set: assert property (cmd && op == 8'hEF |=> wide_bus_o)
        else $error("wide bus not set");
    a_wide_clr: assert property (cmd && op == 8'hE7 |=> !wide_bus_o)
        else $error("wide bus not cleared");
    a_wide_cause: assert property ($changed(wide_bus_o) |-> $past(reg_wr_i))
        else $error("wide bus moved without a write");
    a_tc_cause: assert property (tc_o != $past(tc_o) |-> $past(reg_wr_i) || $past(src))
        else $error("terminal count moved without a count");
    a_save_keeps: assert property (cmd && op[7:5] == CC_SAVE && !src |=> $stable(tc_o))
        else $error("save disturbed terminal count");
    a_disarm_keeps: assert property (cmd && op[7:5] == CC_DISARM && !src |=> $stable(tc_o))
        else $error("disarm left terminal count early");
    a_step_leaves: assert property (cmd && op == 8'hF1 && tc_o[0] |=> !tc_o[0])
        else $error("step did not leave terminal count");
    a_load_ends: assert property (cmd && op[7:6] == 2'b01 && op[0] && tc_o[0] |=> !tc_o[0])
        else $error("load did not end terminal count");
endmodule
bind tcd_top tcd_chk i_tcd_chk (.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .wide_bus_o(wide_bus_o),
    .src_edge_i(src_edge_i), .tc_o(tc_o), .reg_rdata_o(reg_rdata_o));

// ### tb.sv
// Self-checking bench for the timer command decoder.
`timescale 1ns/1ns
module tb;
    import tcd_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, q;
    logic        wr, rd, wide;
    logic [4:0]  tc, cout, src = 5'h00, gate = 5'h00;
    int          mismatches = 0;
    int          n_tests = 0;
    int          seed = 32'hAD56;
    int          armed = 0, tcm = 0, pend = 0, m, g;
    logic [15:0] pexp = 16'h0026;
    always #4 ref_clk_i = ~ref_clk_i;
    tcd_host i_tcd_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    tcd_top i_tcd_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .src_edge_i(src), .gate_i(gate), .reg_rdata_o(rdata),
        .cnt_out_o(cout), .tc_o(tc), .wide_bus_o(wide));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmd(input int c);
        i_tcd_host.wr(OFS_CMD, 16'(c & 255));
    endtask
    task automatic stat;
        i_tcd_host.rd(OFS_STATUS, q);
        check("status", q, 16'(pend << 10 | tcm << 5 | armed));
        check("tc", {11'h000, tc}, 16'(tcm));
    endtask
    initial begin
        #100000;
        mismatches++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        stat;
        cmd(8'hEF);
        check("wide", {15'h0000, wide}, 16'h0001);
        cmd(8'h07);
        i_tcd_host.wr(OFS_DATA, 16'h4000);
        check("wide", {15'h0000, wide}, 16'h0000);
        cmd(8'hEF);
        cmd(8'h09);
        i_tcd_host.wr(OFS_DATA, 16'h0001);
        i_tcd_host.rd(OFS_PTR, q);
        check("ptr", q, 16'h0025);
        cmd(8'hE0);
        i_tcd_host.wr(OFS_DATA, 16'h0001);
        i_tcd_host.rd(OFS_PTR, q);
        check("ptr", q & 16'h001F, 16'h0006);
        for (g = 0; g < 8; g++) begin
            m = $random(seed) & 1;
            cmd(m << 3 | g);
            if (g != 0 && g != 6) pexp = 16'(32 | g << 2 | m);
            i_tcd_host.rd(OFS_PTR, q);
            check("ptr", q, pexp);
        end
        repeat (4) begin
            m = $random(seed) & 31;
            cmd(32 | m);
            armed |= m;
            stat;
            m = $random(seed) & 31;
            cmd(192 | m);
            armed &= ~m;
            stat;
        end
        cmd(8'h41);
        cmd(8'h21);
        armed |= 1;
        cmd(8'hF1);
        tcm = 1;
        stat;
        cmd(8'hA1);
        cmd(8'hC1);
        pend = 1;
        stat;
        cmd(8'h61);
        tcm = 0;
        pend = 0;
        stat;
        cmd(8'h41);
        tcm = 1;
        stat;
        cmd(8'h81);
        pend = 1;
        cmd(8'hF1);
        tcm = 0;
        pend = 0;
        armed &= ~1;
        stat;
        cmd(8'h01);
        i_tcd_host.wr(OFS_DATA, 16'h0842);
        i_tcd_host.wr(OFS_DATA, 16'h0005);
        cmd(8'hE9);
        check("out", {11'h000, cout}, 16'h0001);
        cmd(8'hE1);
        check("out", {11'h000, cout}, 16'h0000);
        repeat (2) begin
            m = $random(seed) & 1;
            @(posedge ref_clk_i) gate <= 5'(m);
            cmd(8'h11);
            i_tcd_host.wr(OFS_DATA, 16'h0009);
            cmd(8'h41);
            cmd(8'hA1);
            cmd(8'h11);
            i_tcd_host.rd(OFS_DATA, q);
            check("hold", q, m ? 16'h0009 : 16'h0005);
        end
        cmd(8'h21);
        armed |= 1;
        @(posedge ref_clk_i) src <= 5'h01;
        @(posedge ref_clk_i) src <= 5'h00;
        cmd(8'hA1);
        cmd(8'h11);
        i_tcd_host.rd(OFS_DATA, q);
        check("hold", q, m ? 16'h0008 : 16'h0004);
        stat;
        cmd(8'hE7);
        check("wide", {15'h0000, wide}, 16'h0000);
        summarize;
    end
endmodule
